/* design/nco_consts.svh */
// Register map, field positions and reset values of the oscillator block.
// Overview of operation
// - Fixed mode toggles output on every overflow.
// - Mode bit clear selects fixed, set selects pulse.
// - Pulse mode drives output active after overflow.
// - Active level starts at first edge after overflow.
// - Three-bit field selects pulse length.
// - Pulse longer than interval holds output steady.
// - Polarity bit is the final output stage.
// - Polarity change raises interrupt for transition.
// - Output level readable as status bit.
// - Output routed to waveform generator source.
// - Accumulator spans three bytes, twenty bits used.
// - Upper accumulator byte reads zero above bit three.
// - Accumulator runs freely, reads are not atomic.
// - Increment buffered, loaded after low byte write.
`ifndef NCO_CONSTS_SVH
`define NCO_CONSTS_SVH

`define NCO_OFF_CTRL     8'h00
`define NCO_OFF_CLKCTL   8'h04
`define NCO_OFF_ACCL     8'h08
`define NCO_OFF_ACCH     8'h0c
`define NCO_OFF_ACCU     8'h10
`define NCO_OFF_INCL     8'h14
`define NCO_OFF_INCH     8'h18
`define NCO_OFF_INCU     8'h1c
`define NCO_OFF_INT_STAT 8'h20
`define NCO_OFF_INT_MASK 8'h24

`define NCO_CTRL_EN      7
`define NCO_CTRL_OUT     5
`define NCO_CTRL_POL     4
`define NCO_CTRL_PFM     0
`define NCO_CLK_PWS_LSB  5

`define NCO_INT_RISE     0
`define NCO_INT_FALL     1

`define NCO_ACC_RST      20'h00000
`define NCO_INC_RST      20'h00001
`define NCO_PWS_RST      3'h0

`endif

/* design/nco_pkg.sv */
// Types shared by the oscillator block modules.
package nco_pkg;

    typedef enum logic {
        MODE_FIXED = 1'b0,
        MODE_PULSE = 1'b1
    } mode_t;

    typedef logic [6:0] pulse_cnt_t;

    // Returns pulse length minus one; the length is two to the power of the select field.
    function automatic pulse_cnt_t pulse_len_m1(input logic [2:0] sel);
        pulse_cnt_t one;
        one = 7'h01;
        return (one << sel) - one;
    endfunction

endpackage

/* design/nco_core.sv */
// Phase accumulator, increment buffer and raw output stage.
`timescale 1ns/1ps
`include "nco_consts.svh"
module nco_core
    import nco_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Control.
    input  wire logic        enable,
    input  wire mode_t       mode,
    input  wire logic [2:0]  width_sel,
    // Increment transfer.
    input  wire logic        inc_load,
    input  wire logic [19:0] inc_word,
    // Accumulator byte writes.
    input  wire logic [2:0]  acc_wr,
    input  wire logic [7:0]  acc_wdata,
    // State.
    output logic [19:0]      acc,
    output logic [19:0]      inc_buf,
    output logic             carry,
    output logic             raw_out
);

    logic [20:0] sum;
    logic [19:0] next_acc;
    logic [19:0] next_inc_buf;
    logic        next_raw;
    pulse_cnt_t  cnt;
    pulse_cnt_t  next_cnt;

    always_comb
    begin
        sum          = {1'b0, acc} + {1'b0, inc_buf};
        carry        = enable & sum[20];
        next_acc     = acc;
        next_inc_buf = inc_buf;
        next_raw     = raw_out;
        next_cnt     = cnt;
        if (inc_load)
            next_inc_buf = inc_word;
        if (enable)
            next_acc = sum[19:0];
        // A write while running lands on top of the step; result is loose.
        if (acc_wr[0])
            next_acc[7:0] = acc_wdata;
        if (acc_wr[1])
            next_acc[15:8] = acc_wdata;
        if (acc_wr[2])
            next_acc[19:16] = acc_wdata[3:0];
        if (!enable)
        begin
            next_raw = 1'b0;
            next_cnt = '0;
        end
        else
        begin
            unique case (mode)
                MODE_FIXED:
                begin
                    if (carry)
                        next_raw = !raw_out;
                    next_cnt = '0;
                end
                MODE_PULSE:
                begin
                    if (carry)
                    begin
                        next_raw = 1'b1;
                        next_cnt = pulse_len_m1(width_sel);
                    end
                    else if (cnt == '0)
                        next_raw = 1'b0;
                    else
                        next_cnt = cnt - 7'h01;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            acc     <= `NCO_ACC_RST;
            inc_buf <= `NCO_INC_RST;
            raw_out <= 1'b0;
            cnt     <= '0;
        end
        else
        begin
            acc     <= next_acc;
            inc_buf <= next_inc_buf;
            raw_out <= next_raw;
            cnt     <= next_cnt;
        end
    end

endmodule

/* design/phase_accumulator_osc.sv */
// Oscillator top: APB register file, polarity stage and interrupt.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "nco_consts.svh"
module phase_accumulator_osc
    import nco_pkg::*;
(
    // Clock and reset.
    input  wire logic        MCLK,
    input  wire logic        RESETN,
    // APB slave.
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    // Interrupt and oscillator output.
    output logic             IRQ,
    output logic             WAVEGEN_SRC
);

    logic        enable;
    logic        pol;
    mode_t       mode;
    logic [2:0]  pws;
    logic [7:0]  inc_lo;
    logic [7:0]  inc_hi;
    logic [3:0]  inc_up;
    logic [1:0]  int_status;
    logic [1:0]  int_mask;
    logic        inc_load;

    logic        next_enable;
    logic        next_pol;
    mode_t       next_mode;
    logic [2:0]  next_pws;
    logic [7:0]  next_inc_lo;
    logic [7:0]  next_inc_hi;
    logic [3:0]  next_inc_up;
    logic [1:0]  next_int_status;
    logic [1:0]  next_int_mask;
    logic        next_inc_load;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        next_irq;
    logic        next_out;

    logic        setup;
    logic        wr;
    logic        rd_done;
    logic        rise;
    logic        fall;
    logic [2:0]  acc_wr;
    logic [19:0] inc_word;
    logic [19:0] acc;
    logic [19:0] inc_buf;
    logic [19:0] acc_step;
    logic        carry;
    logic        raw_out;

    function automatic logic is_mapped(input logic [7:0] a);
        return a == `NCO_OFF_CTRL || a == `NCO_OFF_CLKCTL ||
               a == `NCO_OFF_ACCL || a == `NCO_OFF_ACCH ||
               a == `NCO_OFF_ACCU || a == `NCO_OFF_INCL ||
               a == `NCO_OFF_INCH || a == `NCO_OFF_INCU ||
               a == `NCO_OFF_INT_STAT || a == `NCO_OFF_INT_MASK;
    endfunction

    assign setup    = PSEL & !PENABLE;
    assign wr       = PSEL & PENABLE & PREADY & PWRITE;
    assign rd_done  = PSEL & PENABLE & PREADY & !PWRITE;
    assign inc_word = {inc_up, inc_hi, inc_lo};
    assign acc_step = acc + inc_buf;
    assign acc_wr   = {wr && PADDR == `NCO_OFF_ACCU,
                       wr && PADDR == `NCO_OFF_ACCH,
                       wr && PADDR == `NCO_OFF_ACCL};

    nco_core u_core (
        .clk       (MCLK),
        .rst_n     (RESETN),
        .enable    (enable),
        .mode      (mode),
        .width_sel (pws),
        .inc_load  (inc_load),
        .inc_word  (inc_word),
        .acc_wr    (acc_wr),
        .acc_wdata (PWDATA[7:0]),
        .acc       (acc),
        .inc_buf   (inc_buf),
        .carry     (carry),
        .raw_out   (raw_out)
    );

    // Polarity, edge events and interrupt.
    always_comb
    begin
        next_out = raw_out ^ pol;
        rise     = next_out & !WAVEGEN_SRC;
        fall     = !next_out & WAVEGEN_SRC;
        next_int_status = int_status;
        // Only bits returned by the read are cleared, so a new edge wins.
        if (rd_done && PADDR == `NCO_OFF_INT_STAT)
            next_int_status = int_status & ~PRDATA[1:0];
        next_int_status[`NCO_INT_RISE] =
            next_int_status[`NCO_INT_RISE] | rise;
        next_int_status[`NCO_INT_FALL] =
            next_int_status[`NCO_INT_FALL] | fall;
        next_irq = |(int_status & int_mask);
    end

    // Register writes.
    always_comb
    begin
        next_enable   = enable;
        next_pol      = pol;
        next_mode     = mode;
        next_pws      = pws;
        next_inc_lo   = inc_lo;
        next_inc_hi   = inc_hi;
        next_inc_up   = inc_up;
        next_int_mask = int_mask;
        next_inc_load = wr && PADDR == `NCO_OFF_INCL;
        if (wr)
        begin
            case (PADDR)
                `NCO_OFF_CTRL:
                begin
                    next_enable = PWDATA[`NCO_CTRL_EN];
                    next_pol    = PWDATA[`NCO_CTRL_POL];
                    next_mode   = mode_t'(PWDATA[`NCO_CTRL_PFM]);
                end
                `NCO_OFF_CLKCTL:
                    next_pws = PWDATA[`NCO_CLK_PWS_LSB +: 3];
                `NCO_OFF_INCL:
                    next_inc_lo = PWDATA[7:0];
                `NCO_OFF_INCH:
                    next_inc_hi = PWDATA[7:0];
                `NCO_OFF_INCU:
                    next_inc_up = PWDATA[3:0];
                `NCO_OFF_INT_MASK:
                    next_int_mask = PWDATA[1:0];
                default:
                    next_int_mask = int_mask;
            endcase
        end
    end

    // Read data and bus answer, prepared in the setup cycle.
    always_comb
    begin
        next_pready  = setup;
        next_pslverr = setup & !is_mapped(PADDR);
        next_prdata  = PRDATA;
        if (setup)
        begin
            next_prdata = 32'h0000_0000;
            case (PADDR)
                `NCO_OFF_CTRL:
                begin
                    next_prdata[`NCO_CTRL_EN]  = enable;
                    next_prdata[`NCO_CTRL_OUT] = WAVEGEN_SRC;
                    next_prdata[`NCO_CTRL_POL] = pol;
                    next_prdata[`NCO_CTRL_PFM] = mode;
                end
                `NCO_OFF_CLKCTL:
                    next_prdata[`NCO_CLK_PWS_LSB +: 3] = pws;
                `NCO_OFF_ACCL:
                    next_prdata[7:0] = acc[7:0];
                `NCO_OFF_ACCH:
                    next_prdata[7:0] = acc[15:8];
                `NCO_OFF_ACCU:
                    next_prdata[3:0] = acc[19:16];
                `NCO_OFF_INCL:
                    next_prdata[7:0] = inc_lo;
                `NCO_OFF_INCH:
                    next_prdata[7:0] = inc_hi;
                `NCO_OFF_INCU:
                    next_prdata[3:0] = inc_up;
                `NCO_OFF_INT_STAT:
                    next_prdata[1:0] = int_status;
                `NCO_OFF_INT_MASK:
                    next_prdata[1:0] = int_mask;
                default:
                    next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            enable      <= 1'b0;
            pol         <= 1'b0;
            mode        <= MODE_FIXED;
            pws         <= `NCO_PWS_RST;
            inc_lo      <= 8'(`NCO_INC_RST);
            inc_hi      <= 8'(`NCO_INC_RST >> 8);
            inc_up      <= 4'(`NCO_INC_RST >> 16);
            int_status  <= 2'h0;
            int_mask    <= 2'h0;
            inc_load    <= 1'b0;
            PRDATA      <= 32'h0000_0000;
            PREADY      <= 1'b0;
            PSLVERR     <= 1'b0;
            IRQ         <= 1'b0;
            WAVEGEN_SRC <= 1'b0;
        end
        else
        begin
            enable      <= next_enable;
            pol         <= next_pol;
            mode        <= next_mode;
            pws         <= next_pws;
            inc_lo      <= next_inc_lo;
            inc_hi      <= next_inc_hi;
            inc_up      <= next_inc_up;
            int_status  <= next_int_status;
            int_mask    <= next_int_mask;
            inc_load    <= next_inc_load;
            PRDATA      <= next_prdata;
            PREADY      <= next_pready;
            PSLVERR     <= next_pslverr;
            IRQ         <= next_irq;
            WAVEGEN_SRC <= next_out;
        end
    end

    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);

    sequence s_pulse_start;
        enable && mode == MODE_PULSE && carry && pws == 3'h0;
    endsequence

    sequence s_quiet;
        !carry;
    endsequence

    a_fdc_toggle: assert property (
        enable && mode == MODE_FIXED && carry |=> raw_out != $past(raw_out))
        else $error("fixed mode output did not toggle on overflow");

    a_pf_active: assert property (
        enable && mode == MODE_PULSE && carry |=> raw_out)
        else $error("pulse mode output not active after overflow");

    a_pf_release: assert property (
        s_pulse_start ##1 s_quiet |=> !raw_out)
        else $error("shortest pulse did not end after one cycle");

    a_pf_hold: assert property (
        enable && mode == MODE_PULSE && raw_out && carry |=> raw_out)
        else $error("pulse output dropped on back to back overflow");

    a_pol_out: assert property (
        1'b1 |=> WAVEGEN_SRC == ($past(raw_out) ^ $past(pol)))
        else $error("output does not follow polarity stage");

    a_status_bit: assert property (
        setup && !PWRITE && PADDR == `NCO_OFF_CTRL
        |=> PRDATA[`NCO_CTRL_OUT] == $past(WAVEGEN_SRC))
        else $error("status bit does not show output level");

    a_upper_zero: assert property (
        setup && !PWRITE && PADDR == `NCO_OFF_ACCU
        |=> PRDATA[31:4] == 28'h0 && PRDATA[3:0] == $past(acc[19:16]))
        else $error("upper accumulator byte read wrong");

    a_int_set: assert property (
        $rose(WAVEGEN_SRC) |-> int_status[`NCO_INT_RISE])
        else $error("rising output did not set its flag");

    a_irq_level: assert property (
        (int_status & int_mask) != 2'h0 |=> IRQ)
        else $error("unmasked flag did not raise interrupt");

    a_irq_quiet: assert property (
        (int_status & int_mask) == 2'h0 |=> !IRQ)
        else $error("interrupt high with no unmasked flag");

    a_int_fall: assert property (
        $fell(WAVEGEN_SRC) |-> int_status[`NCO_INT_FALL])
        else $error("falling output did not set its flag");

    a_read_clear: assert property (
        rd_done && PADDR == `NCO_OFF_INT_STAT && PRDATA[0] && !rise
        |=> !int_status[`NCO_INT_RISE])
        else $error("status read did not clear the flag");

    a_inc_transfer: assert property (
        wr && PADDR == `NCO_OFF_INCL |=> inc_load ##1
        inc_buf == $past(inc_word))
        else $error("increment buffer not loaded after low byte");

    a_acc_step: assert property (
        enable && acc_wr == 3'h0 |=> acc == $past(acc_step))
        else $error("accumulator did not add the increment");

endmodule

/* tb/phase_accumulator_osc_bench.sv */
// Self-checking bench for the oscillator block over its APB port.
`timescale 1ns/1ps
`include "nco_consts.svh"
module phase_accumulator_osc_bench
    import nco_pkg::*;
;
    logic        MCLK;
    logic        RESETN;
    logic        PSEL;
    logic        PENABLE;
    logic        PWRITE;
    logic [7:0]  PADDR;
    logic [31:0] PWDATA;
    logic [31:0] PRDATA;
    logic        PREADY;
    logic        PSLVERR;
    logic        IRQ;
    logic        WAVEGEN_SRC;
    int          n_fail;
    int          checked;

    localparam logic [7:0] ADDRS [9] = '{`NCO_OFF_CTRL, `NCO_OFF_CLKCTL,
        `NCO_OFF_ACCL, `NCO_OFF_ACCH, `NCO_OFF_ACCU, `NCO_OFF_INCL,
        `NCO_OFF_INCH, `NCO_OFF_INCU, `NCO_OFF_INT_MASK};
    localparam logic [7:0] RSTV [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h01, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] MASKS [9] = '{8'h00, 8'he0, 8'hff, 8'hff, 8'h0f,
        8'hff, 8'hff, 8'h0f, 8'h03};

    phase_accumulator_osc dut (
        .MCLK        (MCLK),
        .RESETN      (RESETN),
        .PSEL        (PSEL),
        .PENABLE     (PENABLE),
        .PWRITE      (PWRITE),
        .PADDR       (PADDR),
        .PWDATA      (PWDATA),
        .PRDATA      (PRDATA),
        .PREADY      (PREADY),
        .PSLVERR     (PSLVERR),
        .IRQ         (IRQ),
        .WAVEGEN_SRC (WAVEGEN_SRC)
    );

    initial
    begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end

    task automatic end_of_test();
        $display("checked %0d, failed %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic is_wr, input logic [7:0] addr,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int i;
        @(posedge MCLK);
        PSEL    <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE  <= is_wr;
        PADDR   <= addr;
        PWDATA  <= wd;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge MCLK);
            if (PREADY === 1'b1)
                break;
        end
        if (i == 20)
        begin
            n_fail++;
            $display("unexpected wait for bus answer at %h", addr);
            end_of_test();
        end
        rd = PRDATA;
        err = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] a,
                          input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        check(what, r, exp);
        check("bus error", e, 1'b0);
    endtask

    // Cycles until the output differs from its level at entry.
    task automatic next_change(output int n);
        logic v;
        v = WAVEGEN_SRC;
        n = 0;
        while (n < 300)
        begin
            @(posedge MCLK);
            n++;
            if (WAVEGEN_SRC !== v)
                return;
        end
        n_fail++;
        $display("unexpected stall of the oscillator output");
        end_of_test();
    endtask

    // Accumulator is only written while stopped, its results are undefined
    // otherwise.
    task automatic start(input int inc, input logic pfm, input int sel);
        wr(`NCO_OFF_CTRL, 32'h0);
        wr(`NCO_OFF_ACCU, 32'h0);
        wr(`NCO_OFF_ACCH, 32'h0);
        wr(`NCO_OFF_ACCL, 32'h0);
        wr(`NCO_OFF_INCU, (inc >> 16) & 'hf);
        wr(`NCO_OFF_INCH, (inc >> 8) & 'hff);
        wr(`NCO_OFF_INCL, inc & 'hff);
        wr(`NCO_OFF_CLKCTL, sel << 5);
        wr(`NCO_OFF_CTRL, 32'h80 | pfm);
    endtask

    initial
    begin
        int          i;
        int          k;
        int          n;
        int          inc;
        int          phase;
        int          steps;
        int          gaps [$];
        int          chg;
        logic [31:0] w;
        logic [31:0] r;
        logic        e;
        logic        v;
        n_fail = 0;
        checked = 0;
        RESETN = 1'b0;
        PSEL = 1'b0;
        PENABLE = 1'b0;
        PWRITE = 1'b0;
        PADDR = 8'h00;
        PWDATA = 32'h0;
        repeat (10) @(posedge MCLK);
        RESETN <= 1'b1;
        void'($urandom(25930));

        for (i = 0; i < 9; i++)
            rd_chk("reset value", ADDRS[i], RSTV[i]);
        rd_chk("reset status", `NCO_OFF_INT_STAT, 32'h0);
        apb(1'b0, 8'h28, 32'h0, r, e);
        check("unmapped error", e, 1'b1);
        check("unmapped data", r, 32'h0);
        $display("test reset done");

        for (i = 1; i < 9; i++)
        begin
            w = $urandom;
            wr(ADDRS[i], w);
            rd_chk("readback", ADDRS[i], w & MASKS[i]);
        end
        $display("test registers done");

        wr(`NCO_OFF_INT_MASK, 32'h3);
        wr(`NCO_OFF_CTRL, 32'h0);
        apb(1'b0, `NCO_OFF_INT_STAT, 32'h0, r, e);
        check("stopped output", WAVEGEN_SRC, 1'b0);
        wr(`NCO_OFF_CTRL, 32'h10);
        repeat (4) @(posedge MCLK);
        check("inverted output", WAVEGEN_SRC, 1'b1);
        check("irq on flip", IRQ, 1'b1);
        rd_chk("control status", `NCO_OFF_CTRL, 32'h30);
        rd_chk("rise flag", `NCO_OFF_INT_STAT, 32'h1);
        repeat (3) @(posedge MCLK);
        check("irq cleared", IRQ, 1'b0);
        rd_chk("flag cleared", `NCO_OFF_INT_STAT, 32'h0);
        wr(`NCO_OFF_CTRL, 32'h0);
        repeat (4) @(posedge MCLK);
        rd_chk("fall flag", `NCO_OFF_INT_STAT, 32'h2);
        wr(`NCO_OFF_INT_MASK, 32'h0);
        wr(`NCO_OFF_CTRL, 32'h10);
        repeat (4) @(posedge MCLK);
        check("masked irq", IRQ, 1'b0);
        rd_chk("masked flag", `NCO_OFF_INT_STAT, 32'h1);
        $display("test polarity done");

        // The model steps an integer phase from zero and queues the number
        // of cycles between overflows; the first gap only aligns the bench.
        for (k = 0; k < 3; k++)
        begin
            inc = 'h8000 + $urandom % 'h38000;
            phase = 0;
            gaps.delete();
            repeat (8)
            begin
                steps = 0;
                do
                begin
                    phase += inc;
                    steps++;
                end
                while (phase < (1 << 20));
                phase -= 1 << 20;
                gaps.push_back(steps);
            end
            start(inc, 1'b0, 0);
            next_change(n);
            void'(gaps.pop_front());
            repeat (7)
            begin
                next_change(n);
                check("toggle gap", n, gaps.pop_front());
            end
        end
        $display("test fixed mode done");

        for (k = 0; k < 8; k++)
        begin
            start('h10000, 1'b1, k);
            if (k < 4)
            begin
                do
                    next_change(n);
                while (WAVEGEN_SRC !== 1'b1);
                next_change(n);
                check("pulse width", n, 1 << k);
                next_change(n);
                check("pulse gap", n, 16 - (1 << k));
            end
            else if (k > 4)
            begin
                repeat (40) @(posedge MCLK);
                v = WAVEGEN_SRC;
                chg = 0;
                repeat (48)
                begin
                    @(posedge MCLK);
                    chg += (WAVEGEN_SRC !== v);
                end
                check("held level", v, 1'b1);
                check("held changes", chg, 0);
            end
        end
        $display("test pulse mode done");
        end_of_test();
    end
endmodule
